/* inc/tc_pkg.sv */
`default_nettype none
package tc_pkg;

	// Register map, byte addresses on the AXI4-Lite slave
	localparam int        ADDR_W      = 8;
	localparam logic [7:0] OFS_CTRL0   = 8'h00;
	localparam logic [7:0] OFS_CTRL1   = 8'h04;
	localparam logic [7:0] OFS_PWM0    = 8'h08;
	localparam logic [7:0] OFS_PWM1    = 8'h0C;
	localparam logic [7:0] OFS_CMP_LO  = 8'h10;
	localparam logic [7:0] OFS_CMP_HI  = 8'h14;
	localparam logic [7:0] OFS_COUNT   = 8'h18;
	localparam logic [7:0] OFS_SYS     = 8'h1C;

	// counter_control_reg fields
	localparam int RUN_BIT    = 3;
	localparam int FFINIT_BIT = 7;
	localparam int MODE_LSB   = 0;
	localparam int SRC_LSB    = 4;

	// Operating modes, control bits [1:0]
	localparam logic [1:0] MODE_PWM8    = 2'h0;
	localparam logic [1:0] MODE_TIMER16 = 2'h1;
	localparam logic [1:0] MODE_EVENT16 = 2'h2;

	// Source clock taps, control bits [6:4]
	localparam logic [2:0] SRC_DIV11 = 3'h0;
	localparam logic [2:0] SRC_DIV7  = 3'h1;
	localparam logic [2:0] SRC_DIV5  = 3'h2;
	localparam logic [2:0] SRC_DIV3  = 3'h3;
	localparam logic [2:0] SRC_FS    = 3'h4;
	localparam logic [2:0] SRC_DIV1  = 3'h5;
	localparam logic [2:0] SRC_FC    = 3'h6;

	// System register fields
	localparam int DIVSEL_BIT  = 0;
	localparam int LOWSPD_BIT  = 1;

	// Prescaler exponents
	localparam int DIV_W    = 11;
	localparam int EXP_7    = 7;
	localparam int EXP_5    = 5;
	localparam int EXP_3    = 3;
	localparam int FS_DIV_W = 3;

	// Reset values and the 8-bit count limit
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CMP_RESET  = 8'h00;
	localparam logic [7:0] CNT_MAX    = 8'hFF;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : tc_pkg
`default_nettype wire

/* rtl/pin_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module pin_sync
(
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic pin_in,
	output logic      fall_pulse
);

	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			meta_reg <= 1'b1;
			sync_reg <= 1'b1;
			last_reg <= 1'b1;
		end
		else
		begin
			meta_reg <= pin_in;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign fall_pulse = last_reg & ~sync_reg;

endmodule : pin_sync
`default_nettype wire

/* rtl/tick_source.sv */
`timescale 1ns/1ns
`default_nettype none
module tick_source
(
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       fs_edge,
	input  wire logic       divider_select,
	input  wire logic       low_speed,
	input  wire logic [5:0] src_sel,
	output logic      [1:0] tick
);

	logic [tc_pkg::DIV_W-1:0]    div_reg;
	logic [tc_pkg::FS_DIV_W-1:0] fs_div_reg;
	wire logic                   fc_11;
	wire logic                   fc_7;
	wire logic                   fc_5;
	wire logic                   fc_3;
	wire logic                   fc_1;
	wire logic                   fs_8;
	wire logic                   slow_tap;

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			div_reg    <= '0;
			fs_div_reg <= '0;
		end
		else
		begin
			div_reg <= div_reg + 1'b1;
			if (fs_edge)
				fs_div_reg <= fs_div_reg + 1'b1;
		end
	end

	assign fc_11 = &div_reg;
	assign fc_7  = &div_reg[tc_pkg::EXP_7-1:0];
	assign fc_5  = &div_reg[tc_pkg::EXP_5-1:0];
	assign fc_3  = &div_reg[tc_pkg::EXP_3-1:0];
	assign fc_1  = div_reg[0];
	assign fs_8  = fs_edge & (&fs_div_reg);
	// Slowest tap swaps to the low-frequency divider
	assign slow_tap = (divider_select | low_speed) ? fs_8 : fc_11;

	genvar j;
	generate
		for (j = 0; j < 2; j++)
		begin : g_tap
			wire logic [2:0] sel;
			wire logic       fast;
			assign sel = src_sel[j*3 +: 3];
			// High-frequency taps are dead in low-speed modes
			assign fast =
				(sel == tc_pkg::SRC_DIV7) ? fc_7 :
				(sel == tc_pkg::SRC_DIV5) ? fc_5 :
				(sel == tc_pkg::SRC_DIV3) ? fc_3 :
				(sel == tc_pkg::SRC_DIV1) ? fc_1 :
				(sel == tc_pkg::SRC_FC)   ? 1'b1 : 1'b0;
			assign tick[j] =
				(sel == tc_pkg::SRC_DIV11) ? slow_tap :
				(sel == tc_pkg::SRC_FS)    ? fs_edge :
				(fast & ~low_speed);
		end
	endgenerate

endmodule : tick_source
`default_nettype wire

/* rtl/paired_timer_pwm_event_counter.sv */
`timescale 1ns/1ns
`default_nettype none
module paired_timer_pwm_event_counter
(
	input  wire logic                      sys_clk,
	input  wire logic                      rst_n,
	input  wire logic [tc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [tc_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	input  wire logic                      count_input_pin,
	input  wire logic                      low_freq_clock,
	output logic [1:0]                     modulated_out_pin,
	output logic [1:0]                     counter_match_irq
);

	logic [7:0]                aw_addr_reg;
	logic                      aw_have_reg;
	logic [7:0]                w_data_reg;
	logic                      w_lane0_reg;
	logic                      w_have_reg;
	logic                      bvalid_reg;
	logic [1:0]                bresp_reg;
	logic                      awready_reg;
	logic                      wready_reg;
	logic                      arready_reg;
	logic                      rvalid_reg;
	logic [31:0]               rdata_reg;
	logic [1:0]                rresp_reg;
	logic [7:0]                ctrl_reg [2];
	logic [7:0]                pwm_active_reg [2];
	logic [7:0]                pwm_hold_reg [2];
	logic [7:0]                cnt_reg [2];
	logic [1:0]                pin_reg;
	logic [1:0]                irq_reg;
	logic [7:0]                cmp_lo_reg;
	logic [7:0]                cmp_hi_reg;
	logic [1:0]                sys_reg;

	wire logic                 aw_take;
	wire logic                 w_take;
	wire logic                 ar_take;
	wire logic                 wr_fire;
	wire logic                 wr_ok;
	wire logic                 aw_have_next;
	wire logic                 w_have_next;
	wire logic                 bvalid_next;
	wire logic                 rvalid_next;
	wire logic                 wr_hit;
	wire logic                 rd_hit;
	wire logic [31:0]          rd_word;
	wire logic [7:0]           wr_byte;
	wire logic                 fs_edge;
	wire logic                 count_fall;
	wire logic [1:0]           tick;
	wire logic [1:0]           mode_up;
	wire logic                 cascade;
	wire logic                 casc_run;
	wire logic                 casc_inc;
	wire logic                 casc_hit;
	wire logic [15:0]          casc_cnt;
	wire logic [15:0]          casc_next;

	pin_sync u_fs_sync
	(
		.sys_clk    (sys_clk),
		.rst_n      (rst_n),
		.pin_in     (low_freq_clock),
		.fall_pulse (fs_edge)
	);

	pin_sync u_count_sync
	(
		.sys_clk    (sys_clk),
		.rst_n      (rst_n),
		.pin_in     (count_input_pin),
		.fall_pulse (count_fall)
	);

	tick_source u_ticks
	(
		.sys_clk        (sys_clk),
		.rst_n          (rst_n),
		.fs_edge        (fs_edge),
		.divider_select (sys_reg[tc_pkg::DIVSEL_BIT]),
		.low_speed      (sys_reg[tc_pkg::LOWSPD_BIT]),
		.src_sel        ({ctrl_reg[1][tc_pkg::SRC_LSB +: 3],
			ctrl_reg[0][tc_pkg::SRC_LSB +: 3]}),
		.tick           (tick)
	);

	// AXI4-Lite channel bookkeeping; one write and one read in flight
	assign aw_take      = s_axi_awvalid & awready_reg;
	assign w_take       = s_axi_wvalid & wready_reg;
	assign ar_take      = s_axi_arvalid & arready_reg;
	assign wr_fire      = aw_have_reg & w_have_reg & ~bvalid_reg;
	assign aw_have_next = (aw_have_reg & ~wr_fire) | aw_take;
	assign w_have_next  = (w_have_reg & ~wr_fire) | w_take;
	assign bvalid_next  = (bvalid_reg & ~s_axi_bready) | wr_fire;
	assign rvalid_next  = (rvalid_reg & ~s_axi_rready) | ar_take;
	assign wr_byte      = w_data_reg;
	assign wr_ok        = wr_fire & w_lane0_reg;

	assign wr_hit = (aw_addr_reg == tc_pkg::OFS_CTRL0) ||
		(aw_addr_reg == tc_pkg::OFS_CTRL1) ||
		(aw_addr_reg == tc_pkg::OFS_PWM0) ||
		(aw_addr_reg == tc_pkg::OFS_PWM1) ||
		(aw_addr_reg == tc_pkg::OFS_CMP_LO) ||
		(aw_addr_reg == tc_pkg::OFS_CMP_HI) ||
		(aw_addr_reg == tc_pkg::OFS_COUNT) ||
		(aw_addr_reg == tc_pkg::OFS_SYS);
	assign rd_hit = (s_axi_araddr == tc_pkg::OFS_CTRL0) ||
		(s_axi_araddr == tc_pkg::OFS_CTRL1) ||
		(s_axi_araddr == tc_pkg::OFS_PWM0) ||
		(s_axi_araddr == tc_pkg::OFS_PWM1) ||
		(s_axi_araddr == tc_pkg::OFS_CMP_LO) ||
		(s_axi_araddr == tc_pkg::OFS_CMP_HI) ||
		(s_axi_araddr == tc_pkg::OFS_COUNT) ||
		(s_axi_araddr == tc_pkg::OFS_SYS);

	// Compare reads show the active value, never the holding stage
	assign rd_word =
		(s_axi_araddr == tc_pkg::OFS_CTRL0)  ? {24'h0, ctrl_reg[0]} :
		(s_axi_araddr == tc_pkg::OFS_CTRL1)  ? {24'h0, ctrl_reg[1]} :
		(s_axi_araddr == tc_pkg::OFS_PWM0)   ? {24'h0, pwm_active_reg[0]} :
		(s_axi_araddr == tc_pkg::OFS_PWM1)   ? {24'h0, pwm_active_reg[1]} :
		(s_axi_araddr == tc_pkg::OFS_CMP_LO) ? {24'h0, cmp_lo_reg} :
		(s_axi_araddr == tc_pkg::OFS_CMP_HI) ? {24'h0, cmp_hi_reg} :
		(s_axi_araddr == tc_pkg::OFS_COUNT)  ? {16'h0, casc_cnt} :
		(s_axi_araddr == tc_pkg::OFS_SYS)    ? {30'h0, sys_reg} : 32'h0;

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg  <= 8'h00;
			w_lane0_reg <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= tc_pkg::RESP_OKAY;
			awready_reg <= 1'b0;
			wready_reg  <= 1'b0;
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0;
			rresp_reg   <= tc_pkg::RESP_OKAY;
		end
		else
		begin
			aw_have_reg <= aw_have_next;
			w_have_reg  <= w_have_next;
			bvalid_reg  <= bvalid_next;
			rvalid_reg  <= rvalid_next;
			awready_reg <= ~aw_have_next & ~bvalid_next;
			wready_reg  <= ~w_have_next & ~bvalid_next;
			arready_reg <= ~rvalid_next;
			if (aw_take)
				aw_addr_reg <= s_axi_awaddr;
			if (w_take)
			begin
				w_data_reg  <= s_axi_wdata[7:0];
				w_lane0_reg <= s_axi_wstrb[0];
			end
			if (wr_fire)
				bresp_reg <= wr_hit ? tc_pkg::RESP_OKAY : tc_pkg::RESP_SLVERR;
			if (ar_take)
			begin
				rdata_reg <= rd_word;
				rresp_reg <= rd_hit ? tc_pkg::RESP_OKAY : tc_pkg::RESP_SLVERR;
			end
		end
	end

	// Cascaded 16-bit timer / event counter, steered by the upper control
	assign mode_up  = ctrl_reg[1][tc_pkg::MODE_LSB +: 2];
	assign cascade  = (mode_up == tc_pkg::MODE_TIMER16) ||
		(mode_up == tc_pkg::MODE_EVENT16);
	assign casc_run = cascade & ctrl_reg[1][tc_pkg::RUN_BIT];
	// Internal tap in timer mode, pin falling edge in event mode
	assign casc_inc = casc_run &
		((mode_up == tc_pkg::MODE_EVENT16) ? count_fall : tick[0]);
	assign casc_cnt = {cnt_reg[1], cnt_reg[0]};
	// Compare bytes used directly, no holding stage
	assign casc_hit = casc_inc & (casc_cnt == {cmp_hi_reg, cmp_lo_reg});
	assign casc_next = !casc_run ? 16'h0 :
		casc_hit ? 16'h0 :
		casc_inc ? casc_cnt + 16'h1 : casc_cnt;

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			cmp_lo_reg <= tc_pkg::CMP_RESET;
			cmp_hi_reg <= tc_pkg::CMP_RESET;
			sys_reg    <= 2'h0;
		end
		else if (wr_ok)
		begin
			if (aw_addr_reg == tc_pkg::OFS_CMP_LO)
				cmp_lo_reg <= wr_byte;
			if (aw_addr_reg == tc_pkg::OFS_CMP_HI)
				cmp_hi_reg <= wr_byte;
			if (aw_addr_reg == tc_pkg::OFS_SYS)
				sys_reg <= wr_byte[1:0];
		end
	end

	genvar j;
	generate
		for (j = 0; j < 2; j++)
		begin : g_ch
			wire logic [7:0] ofs_ctrl;
			wire logic [7:0] ofs_pwm;
			wire logic       running;
			wire logic       pwm_on;
			wire logic       pwm_step;
			wire logic       pwm_match;
			wire logic       pwm_ovf;
			wire logic       ctrl_wr;
			wire logic       pwm_wr;
			wire logic       ff_load;

			assign ofs_ctrl = (j == 0) ? tc_pkg::OFS_CTRL0 : tc_pkg::OFS_CTRL1;
			assign ofs_pwm  = (j == 0) ? tc_pkg::OFS_PWM0 : tc_pkg::OFS_PWM1;
			assign running  = ctrl_reg[j][tc_pkg::RUN_BIT];
			assign pwm_on   = running & ~cascade &
				(ctrl_reg[j][tc_pkg::MODE_LSB +: 2] == tc_pkg::MODE_PWM8);
			assign pwm_step  = pwm_on & tick[j];
			assign pwm_match = pwm_step &
				(cnt_reg[j] == pwm_active_reg[j]);
			assign pwm_ovf   = pwm_step & (cnt_reg[j] == tc_pkg::CNT_MAX);
			assign ctrl_wr   = wr_ok & (aw_addr_reg == ofs_ctrl);
			assign pwm_wr    = wr_ok & (aw_addr_reg == ofs_pwm);
			// Only a write that finds the counter stopped moves the level,
			// so the stopping write itself leaves the pin alone
			assign ff_load   = ctrl_wr & ~running;

			always_ff @(posedge sys_clk)
			begin
				if (!rst_n)
				begin
					ctrl_reg[j]       <= tc_pkg::CTRL_RESET;
					pwm_active_reg[j] <= tc_pkg::CMP_RESET;
					pwm_hold_reg[j]   <= tc_pkg::CMP_RESET;
					cnt_reg[j]        <= 8'h00;
					pin_reg[j]        <= 1'b1;
					irq_reg[j]        <= 1'b0;
				end
				else
				begin
					if (ctrl_wr)
						ctrl_reg[j] <= wr_byte;
					if (pwm_wr)
						pwm_hold_reg[j] <= wr_byte;
					if (pwm_wr && !pwm_on)
						pwm_active_reg[j] <= wr_byte;
					else if (pwm_ovf)
						pwm_active_reg[j] <= pwm_hold_reg[j];
					if (cascade)
						cnt_reg[j] <= casc_next[j*8 +: 8];
					else if (!pwm_on || pwm_ovf)
						cnt_reg[j] <= 8'h00;
					else if (pwm_step)
						cnt_reg[j] <= cnt_reg[j] + 8'h01;
					// Pin register holds the inverse of the flip-flop
					if (ff_load)
						pin_reg[j] <= ~wr_byte[tc_pkg::FFINIT_BIT];
					else if (pwm_match ^ pwm_ovf)
						pin_reg[j] <= ~pin_reg[j];
					irq_reg[j] <= pwm_ovf | ((j == 1) & casc_hit);
				end
			end
		end
	endgenerate

	assign s_axi_awready     = awready_reg;
	assign s_axi_wready      = wready_reg;
	assign s_axi_bvalid      = bvalid_reg;
	assign s_axi_bresp       = bresp_reg;
	assign s_axi_arready     = arready_reg;
	assign s_axi_rvalid      = rvalid_reg;
	assign s_axi_rdata       = rdata_reg;
	assign s_axi_rresp       = rresp_reg;
	assign modulated_out_pin = pin_reg;
	assign counter_match_irq = irq_reg;

endmodule : paired_timer_pwm_event_counter
`default_nettype wire

/* bench/paired_timer_pwm_event_counter_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module paired_timer_pwm_event_counter_checker
(
	input wire logic                      sys_clk,
	input wire logic                      rst_n,
	input wire logic [tc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic                      s_axi_awvalid,
	input wire logic                      s_axi_awready,
	input wire logic [31:0]               s_axi_wdata,
	input wire logic [3:0]                s_axi_wstrb,
	input wire logic                      s_axi_wvalid,
	input wire logic                      s_axi_wready,
	input wire logic [1:0]                s_axi_bresp,
	input wire logic                      s_axi_bvalid,
	input wire logic                      s_axi_bready,
	input wire logic                      s_axi_arvalid,
	input wire logic                      s_axi_arready,
	input wire logic [31:0]               s_axi_rdata,
	input wire logic                      s_axi_rvalid,
	input wire logic                      s_axi_rready,
	input wire logic [1:0]                counter_match_irq
);
	logic [7:0] waddr_q;
	logic [7:0] wbyte_q;
	logic       wen_q;
	logic       bv_q;
	logic       run0_q;
	// Shadow of counter 0 run bit, one cycle late on purpose
	wire logic  ctl0_wr = s_axi_bvalid && !bv_q && wen_q
		&& waddr_q == tc_pkg::OFS_CTRL0;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	always_ff @(posedge sys_clk)
	begin
		bv_q <= s_axi_bvalid;
		if (s_axi_awvalid && s_axi_awready)
			waddr_q <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready)
		begin
			wbyte_q <= s_axi_wdata[7:0];
			wen_q   <= s_axi_wstrb[0];
		end
		if (!rst_n)
			run0_q <= 1'b0;
		else if (ctl0_wr)
			run0_q <= wbyte_q[tc_pkg::RUN_BIT];
	end

	property p_wr_resp;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|=> !s_axi_bvalid ##1 s_axi_bvalid;
	endproperty
	a_wr_resp: assert property (p_wr_resp)
		else $error("late write response");
	property p_rd_resp;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_resp: assert property (p_rd_resp)
		else $error("late read data");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read data dropped");
	property p_r_upper;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
	endproperty
	a_r_upper: assert property (p_r_upper)
		else $error("upper read bits set");
	property p_ar_busy;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_busy: assert property (p_ar_busy)
		else $error("read accepted early");
	// Overflow of an 8-bit count cannot repeat within 8 ticks
	property p_irq0_gap;
		counter_match_irq[0] |=> (!counter_match_irq[0])[*8];
	endproperty
	a_irq0_gap: assert property (p_irq0_gap)
		else $error("irq too close");
	property p_stop_quiet;
		(!run0_q)[*3] |-> !counter_match_irq[0];
	endproperty
	a_stop_quiet: assert property (p_stop_quiet)
		else $error("irq while stopped");

	c_irq0: cover property (counter_match_irq[0]);
	c_irq1: cover property (counter_match_irq[1]);
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == tc_pkg::RESP_SLVERR);
endmodule : paired_timer_pwm_event_counter_checker

bind paired_timer_pwm_event_counter paired_timer_pwm_event_counter_checker
	checker_inst (.sys_clk(sys_clk), .rst_n(rst_n),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
	.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .counter_match_irq(counter_match_irq));
`default_nettype wire

/* bench/paired_timer_pwm_event_counter_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module paired_timer_pwm_event_counter_tb;
	typedef struct packed
	{
		logic [7:0] addr;
		logic [7:0] wd;
		logic [1:0] resp;
		logic [7:0] rd;
	} row_type;

	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic        s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        cin = 1'b1;
	logic [4:0]  lfc = 5'h00;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, pin, irq;
	logic [31:0] s_axi_rdata;
	int          err_total = 0;
	int          checks_done = 0;
	int          cyc = 0;
	int          n0 = 0;
	int          n1 = 0;
	// Counter 0 taps driving the cascade; 10 ticks per cascade period
	logic [2:0]  taps [5] = '{tc_pkg::SRC_DIV7, tc_pkg::SRC_DIV5,
		tc_pkg::SRC_DIV3, tc_pkg::SRC_FS, tc_pkg::SRC_DIV1};
	// Slow clock of the bench falls once every 32 cycles
	logic [31:0] tap_per [5] = '{32'hA << tc_pkg::EXP_7,
		32'hA << tc_pkg::EXP_5, 32'hA << tc_pkg::EXP_3, 32'h140, 32'h14};
	// Counter 1 idle first; cascade compare upper byte before lower
	row_type     rows [8] = '{
		'{tc_pkg::OFS_CTRL0, 8'h60, tc_pkg::RESP_OKAY, 8'h60},
		'{tc_pkg::OFS_CTRL1, 8'h63, tc_pkg::RESP_OKAY, 8'h63},
		'{tc_pkg::OFS_PWM0, 8'h40, tc_pkg::RESP_OKAY, 8'h40},
		'{tc_pkg::OFS_PWM1, 8'h80, tc_pkg::RESP_OKAY, 8'h80},
		'{tc_pkg::OFS_CMP_HI, 8'h00, tc_pkg::RESP_OKAY, 8'h00},
		'{tc_pkg::OFS_CMP_LO, 8'h09, tc_pkg::RESP_OKAY, 8'h09},
		'{tc_pkg::OFS_COUNT, 8'hFF, tc_pkg::RESP_OKAY, 8'h00},
		'{8'h20, 8'h5A, tc_pkg::RESP_SLVERR, 8'h00}};

	paired_timer_pwm_event_counter paired_timer_pwm_event_counter_inst
	(
		.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.count_input_pin(cin), .low_freq_clock(lfc[4]),
		.modulated_out_pin(pin), .counter_match_irq(irq)
	);

	initial
		forever #4 sys_clk = ~sys_clk;

	task automatic end_sim;
		if (err_total == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim

	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		lfc <= lfc + 5'h01;
		if (irq[0] === 1'b1)
			n0 <= n0 + 1;
		if (irq[1] === 1'b1)
			n1 <= n1 + 1;
		if (cyc == 20000)
		begin
			err_total++;
			end_sim();
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// Response ready is offered with the request and held until answered
	task automatic axi_wr(input logic [7:0] a, d, input logic [1:0] er);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
	endtask : axi_wr

	task automatic rd_chk(input logic [7:0] a, e, input logic [1:0] er);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk("rdata", s_axi_rdata, {24'h000000, e});
		chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
	endtask : rd_chk

	// Cycles to the next irq of counter b, and to the first low pin level
	task automatic period(input int b, output int per, fall);
		per = 0;
		fall = 0;
		do
		begin
			@(negedge sys_clk);
			per++;
			if (pin[b] === 1'b0 && fall == 0)
				fall = per;
		end
		while (irq[b] !== 1'b1 && per < 2000);
	endtask : period

	initial
	begin
		int per;
		int fall;
		int b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(negedge sys_clk);
		chk("pins", {30'h0, pin}, 32'h3);
		rd_chk(tc_pkg::OFS_CTRL0, 8'h00, tc_pkg::RESP_OKAY);
		for (int i = 0; i < 8; i++)
		begin
			axi_wr(rows[i].addr, rows[i].wd, rows[i].resp);
			rd_chk(rows[i].addr, rows[i].rd, rows[i].resp);
		end
		// Write without lane 0 must leave the control byte alone
		s_axi_wstrb <= 4'h0;
		axi_wr(tc_pkg::OFS_CTRL0, 8'hFF, tc_pkg::RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		rd_chk(tc_pkg::OFS_CTRL0, 8'h60, tc_pkg::RESP_OKAY);
		axi_wr(tc_pkg::OFS_CTRL0, 8'h68, tc_pkg::RESP_OKAY);
		period(0, per, fall);
		period(0, per, fall);
		chk("pwm period", 32'(per), 32'h100);
		chk("pwm high", 32'(fall), 32'h41);
		axi_wr(tc_pkg::OFS_PWM0, 8'h20, tc_pkg::RESP_OKAY);
		rd_chk(tc_pkg::OFS_PWM0, 8'h40, tc_pkg::RESP_OKAY);
		period(0, per, fall);
		period(0, per, fall);
		chk("pwm high new", 32'(fall), 32'h21);
		rd_chk(tc_pkg::OFS_PWM0, 8'h20, tc_pkg::RESP_OKAY);
		while (pin[0] !== 1'b0)
			@(negedge sys_clk);
		axi_wr(tc_pkg::OFS_CTRL0, 8'h60, tc_pkg::RESP_OKAY);
		b0 = n0;
		repeat (300) @(negedge sys_clk);
		chk("held pin", {31'h0, pin[0]}, 32'h0);
		chk("stopped irq", 32'(n0 - b0), 32'h0);
		axi_wr(tc_pkg::OFS_CTRL0, 8'h60, tc_pkg::RESP_OKAY);
		repeat (3) @(negedge sys_clk);
		chk("pin high", {31'h0, pin[0]}, 32'h1);
		axi_wr(tc_pkg::OFS_SYS, 8'h02, tc_pkg::RESP_OKAY);
		axi_wr(tc_pkg::OFS_CTRL0, 8'h68, tc_pkg::RESP_OKAY);
		b0 = n0;
		repeat (600) @(negedge sys_clk);
		chk("slow taps", 32'(n0 - b0), 32'h0);
		axi_wr(tc_pkg::OFS_CTRL0, 8'h60, tc_pkg::RESP_OKAY);
		axi_wr(tc_pkg::OFS_SYS, 8'h00, tc_pkg::RESP_OKAY);
		axi_wr(tc_pkg::OFS_CTRL1, 8'h69, tc_pkg::RESP_OKAY);
		period(1, per, fall);
		period(1, per, fall);
		chk("cascade period", 32'(per), 32'hA);
		for (int t = 0; t < 5; t++)
		begin
			axi_wr(tc_pkg::OFS_CTRL0, {1'b0, taps[t], 4'h0}, tc_pkg::RESP_OKAY);
			period(1, per, fall);
			period(1, per, fall);
			chk("tap period", 32'(per), tap_per[t]);
		end
		axi_wr(tc_pkg::OFS_CTRL1, 8'h61, tc_pkg::RESP_OKAY);
		axi_wr(tc_pkg::OFS_CMP_LO, 8'h02, tc_pkg::RESP_OKAY);
		axi_wr(tc_pkg::OFS_CMP_HI, 8'h00, tc_pkg::RESP_OKAY);
		axi_wr(tc_pkg::OFS_CTRL1, 8'h0A, tc_pkg::RESP_OKAY);
		b0 = n1;
		// Eight cycles per level keeps well above the minimum pulse width
		for (int i = 1; i <= 6; i++)
		begin
			repeat (8) @(posedge sys_clk);
			cin <= 1'b0;
			repeat (8) @(posedge sys_clk);
			cin <= 1'b1;
			chk("events", 32'(n1 - b0), 32'(i / 3));
		end
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(negedge sys_clk);
		chk("pins again", {30'h0, pin}, 32'h3);
		rd_chk(tc_pkg::OFS_CTRL1, 8'h00, tc_pkg::RESP_OKAY);
		end_sim();
	end
endmodule : paired_timer_pwm_event_counter_tb
`default_nettype wire
